// file: src/status_trigger_map.vh
// constants for the status filter, error queue and trigger sequencer
// Overview of operation
// [RQ1] falling filter bit passes one-to-zero changes
// [RQ2] rising filter bit passes zero-to-one changes
// [RQ3] both filter bits pass any change
// [RQ4] neither filter bit blocks all changes
// [RQ5] filters hold 0..32767, preset 0 and 32767
// [RQ6] errors queued in arrival order with number
// [RQ7] queue read returns oldest and removes it
// [RQ8] empty queue read returns zero, no error
// [RQ9] overflow makes last entry too-many-errors code
// [RQ10] front panel errors bypass the remote queue
// [RQ11] sequence 1 transient default, 2 acquire
// [RQ12] abort cancels triggers, reloads pending levels
// [RQ13] abort clears waiting-for-trigger flag
// [RQ14] continuous mode re-initiates right after abort
// [RQ15] abort at power-on, recall and reset
// [RQ16] uninitiated sequence ignores its triggers
// [RQ17] non-continuous: one trigger per initiate
// [RQ18] accepted bus trigger applies pending level
// [RQ19] waiting flag is OR of both sequences
// [RQ20] continuous mode re-arms at once after trigger
// [RQ21] transient triggers come only from bus source
// [RQ22] event bits latch, read returns then clears
// [RQ23] summary bit is OR of enabled events
// [RQ24] edges found against previous-cycle condition
`ifndef STATUS_TRIGGER_MAP_VH
`define STATUS_TRIGGER_MAP_VH
`define QUESTIONABLE_SUMMARY_WIDTH 15
`define FALLING_FILTER_RESET 15'h0000
`define RISING_FILTER_RESET 15'h7FFF
`define QUESTIONABLE_SUMMARY_ENABLE_RESET 15'h0000
`define ERR_NUM_WIDTH 16
`define ERR_DEPTH 8
`define ERR_PTR_WIDTH 3
`define ERR_CNT_WIDTH 4
`define ERR_NONE 16'h0000
`define ERR_TOO_MANY 16'hFEA2
`define SEQ_TRANSIENT 2'h1
`define SEQ_ACQUIRE 2'h2
`define LEVEL_WIDTH 16
`endif

// file: src/error_queue.v
// first-in first-out queue of remote error numbers
`timescale 1ns/1ns
`include "status_trigger_map.vh"
module error_queue
(
  // clock and reset
  input wire clk_in,
  input wire reset_in,
  // error entry and read
  input wire push_in,
  input wire [`ERR_NUM_WIDTH-1:0] push_num_in,
  input wire pop_in,
  // head and state
  output reg [`ERR_NUM_WIDTH-1:0] read_num_out,
  output reg empty_out,
  output reg [`ERR_CNT_WIDTH-1:0] count_out
);
  reg [`ERR_NUM_WIDTH-1:0] mem [0:`ERR_DEPTH-1];
  reg [`ERR_PTR_WIDTH-1:0] rd_ptr_reg;
  reg [`ERR_PTR_WIDTH-1:0] wr_ptr_reg;
  reg [`ERR_CNT_WIDTH-1:0] cnt_reg;
  wire do_pop;
  wire do_push;
  wire full;
  wire [`ERR_PTR_WIDTH-1:0] last_ptr;
  wire [`ERR_CNT_WIDTH-1:0] cnt_next;
  assign do_pop = pop_in && (cnt_reg != {`ERR_CNT_WIDTH{1'b0}});
  assign full = (cnt_reg == `ERR_DEPTH);
  assign do_push = push_in && (!full || do_pop);
  assign last_ptr = wr_ptr_reg - 3'h1;
  assign cnt_next = cnt_reg + {3'h0, do_push} - {3'h0, do_pop};
  always @(posedge clk_in)
  begin
    if (do_push) // RQ6
      mem[wr_ptr_reg] <= push_num_in;
    else if (push_in && full) // RQ9
      mem[last_ptr] <= `ERR_TOO_MANY;
  end
  always @(posedge clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      rd_ptr_reg <= 3'h0;
      wr_ptr_reg <= 3'h0;
      cnt_reg <= 4'h0;
    end
    else
    begin
      if (do_pop) // RQ7
        rd_ptr_reg <= rd_ptr_reg + 3'h1;
      if (do_push)
        wr_ptr_reg <= wr_ptr_reg + 3'h1;
      cnt_reg <= cnt_next;
    end
  end
  always @(posedge clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      read_num_out <= `ERR_NONE;
      empty_out <= 1'b1;
      count_out <= 4'h0;
    end
    else
    begin
      if (!pop_in)
        read_num_out <= read_num_out;
      else if (cnt_reg == 4'h0) // RQ8
        read_num_out <= `ERR_NONE;
      else
        read_num_out <= mem[rd_ptr_reg];
      empty_out <= (cnt_next == 4'h0);
      count_out <= cnt_next;
    end
  end
endmodule // error_queue

// file: src/status_filter_trigger_control.v
// questionable filters, error queue and transient trigger sequencer
`timescale 1ns/1ns
`include "status_trigger_map.vh"
module status_filter_trigger_control
(
  // clock and reset
  input wire clk_in,
  input wire reset_in,
  // filter and mask register writes and reads
  input wire falling_write_in,
  input wire rising_write_in,
  input wire enable_write_in,
  input wire [`QUESTIONABLE_SUMMARY_WIDTH-1:0] write_data_in,
  input wire event_read_in,
  // questionable condition from the hardware
  input wire [`QUESTIONABLE_SUMMARY_WIDTH-1:0] condition_in,
  // error sources
  input wire remote_error_in,
  input wire front_panel_error_in,
  input wire [`ERR_NUM_WIDTH-1:0] error_num_in,
  input wire error_read_in,
  // trigger commands
  input wire abort_in,
  input wire recall_in,
  input wire reset_cmd_in,
  input wire initiate_in,
  input wire [1:0] initiate_seq_in,
  input wire continuous_write_in,
  input wire continuous_in,
  input wire bus_trigger_in,
  input wire acquire_done_in,
  // levels
  input wire [`LEVEL_WIDTH-1:0] immediate_level_in,
  input wire pending_write_in,
  input wire [`LEVEL_WIDTH-1:0] pending_level_in,
  // register read-back
  output reg [`QUESTIONABLE_SUMMARY_WIDTH-1:0] falling_edge_filter_out,
  output reg [`QUESTIONABLE_SUMMARY_WIDTH-1:0] rising_edge_filter_out,
  output reg [`QUESTIONABLE_SUMMARY_WIDTH-1:0] questionable_summary_enable_out,
  output reg [`QUESTIONABLE_SUMMARY_WIDTH-1:0] event_read_data_out,
  output reg [`QUESTIONABLE_SUMMARY_WIDTH-1:0] condition_out,
  output reg questionable_summary_out,
  // error queue
  output wire [`ERR_NUM_WIDTH-1:0] error_read_num_out,
  output wire error_empty_out,
  output wire [`ERR_CNT_WIDTH-1:0] error_count_out,
  output reg [`ERR_NUM_WIDTH-1:0] display_error_out,
  output reg display_error_valid_out,
  // trigger state
  output reg waiting_for_trigger_flag_out,
  output reg transient_armed_out,
  output reg acquire_armed_out,
  output reg continuous_out,
  output reg [`LEVEL_WIDTH-1:0] output_level_out,
  output reg [`LEVEL_WIDTH-1:0] pending_level_out,
  output reg level_applied_out
);
  reg [`QUESTIONABLE_SUMMARY_WIDTH-1:0] cond_prev_reg;
  reg [`QUESTIONABLE_SUMMARY_WIDTH-1:0] event_reg;
  reg [`QUESTIONABLE_SUMMARY_WIDTH-1:0] event_next;
  reg cond_valid_reg;
  reg power_on_reg;
  reg trans_state_reg;
  reg trans_state_next;
  reg acquire_armed_next;
  reg [`LEVEL_WIDTH-1:0] pending_next;
  reg [`LEVEL_WIDTH-1:0] output_next;
  // transient sequence states
  localparam TRANS_IDLE = 1'b0;
  localparam TRANS_ARMED = 1'b1;
  wire [`QUESTIONABLE_SUMMARY_WIDTH-1:0] passed;
  wire abort_now;
  wire trig_accept;
  wire trans_init;
  wire acq_init;

  // per-bit filter; both zero blocks, both one passes any change
  function [`QUESTIONABLE_SUMMARY_WIDTH-1:0] edge_pass;
    input [`QUESTIONABLE_SUMMARY_WIDTH-1:0] now_bits;
    input [`QUESTIONABLE_SUMMARY_WIDTH-1:0] prev_bits;
    input [`QUESTIONABLE_SUMMARY_WIDTH-1:0] rise_mask;
    input [`QUESTIONABLE_SUMMARY_WIDTH-1:0] fall_mask;
    begin
      edge_pass = (now_bits & ~prev_bits & rise_mask) | // RQ2 RQ3 RQ4
        (~now_bits & prev_bits & fall_mask); // RQ1 RQ3 RQ4
    end
  endfunction

  // initiate sequence number decode
  function seq_match;
    input [1:0] seq;
    input [1:0] code;
    begin
      seq_match = (seq == code);
    end
  endfunction

  // edge detect against previous cycle, none in first cycle after reset
  assign passed = cond_valid_reg ?
    edge_pass(condition_in, cond_prev_reg, rising_edge_filter_out,
      falling_edge_filter_out) : // RQ24
    {`QUESTIONABLE_SUMMARY_WIDTH{1'b0}};

  always @*
  begin
    event_next = event_reg;
    if (event_read_in)
      event_next = {`QUESTIONABLE_SUMMARY_WIDTH{1'b0}};
    event_next = event_next | passed; // RQ22
  end

  // condition pipeline for edge detect and read-back
  always @(posedge clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      cond_prev_reg <= 15'h0000;
      cond_valid_reg <= 1'b0;
      condition_out <= 15'h0000;
    end
    else
    begin
      cond_prev_reg <= condition_in; // RQ24
      cond_valid_reg <= 1'b1;
      condition_out <= condition_in;
    end
  end

  // filter and enable mask registers
  always @(posedge clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      falling_edge_filter_out <= `FALLING_FILTER_RESET;
      rising_edge_filter_out <= `RISING_FILTER_RESET;
      questionable_summary_enable_out <= `QUESTIONABLE_SUMMARY_ENABLE_RESET;
    end
    else
    begin
      if (falling_write_in) // RQ5
        falling_edge_filter_out <= write_data_in;
      if (rising_write_in) // RQ5
        rising_edge_filter_out <= write_data_in;
      if (enable_write_in)
        questionable_summary_enable_out <= write_data_in;
    end
  end

  // latched events, read clears all but bits set in the same cycle
  always @(posedge clk_in or posedge reset_in)
  begin
    if (reset_in)
      event_reg <= 15'h0000;
    else
      event_reg <= event_next; // RQ22
  end

  // read-back of the events as they stood before the clear
  always @(posedge clk_in or posedge reset_in)
  begin
    if (reset_in)
      event_read_data_out <= 15'h0000;
    else if (event_read_in) // RQ22
      event_read_data_out <= event_reg;
  end

  // summary follows the latched events under the mask
  always @(posedge clk_in or posedge reset_in)
  begin
    if (reset_in)
      questionable_summary_out <= 1'b0;
    else
      questionable_summary_out <= |(event_next & questionable_summary_enable_out); // RQ23
  end

  // remote errors queue, front panel errors go straight to display
  error_queue u_error_queue
  (
    .clk_in(clk_in),
    .reset_in(reset_in),
    .push_in(remote_error_in), // RQ6
    .push_num_in(error_num_in),
    .pop_in(error_read_in),
    .read_num_out(error_read_num_out),
    .empty_out(error_empty_out),
    .count_out(error_count_out)
  );

  always @(posedge clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      display_error_out <= `ERR_NONE;
      display_error_valid_out <= 1'b0;
    end
    else
    begin
      display_error_valid_out <= front_panel_error_in; // RQ10
      if (front_panel_error_in) // RQ10
        display_error_out <= error_num_in;
    end
  end

  // abort sources, including the first cycle after power-on
  always @(posedge clk_in or posedge reset_in)
  begin
    if (reset_in)
      power_on_reg <= 1'b1;
    else
      power_on_reg <= 1'b0;
  end
  assign abort_now = abort_in | recall_in | reset_cmd_in |
    power_on_reg; // RQ15
  assign trans_init = initiate_in &&
    seq_match(initiate_seq_in, `SEQ_TRANSIENT); // RQ11
  assign acq_init = initiate_in &&
    seq_match(initiate_seq_in, `SEQ_ACQUIRE); // RQ11
  // only bus trigger reaches the transient sequence, only when armed
  assign trig_accept = bus_trigger_in &&
    (trans_state_reg == TRANS_ARMED) && !abort_now; // RQ16 RQ21

  // transient sequence; abort beats initiate and trigger
  always @*
  begin
    trans_state_next = trans_state_reg;
    if (abort_now)
    begin
      if (continuous_out) // RQ14
        trans_state_next = TRANS_ARMED;
      else
        trans_state_next = TRANS_IDLE; // RQ12
    end
    else
    begin
      case (trans_state_reg)
        TRANS_IDLE:
        begin
          if (trans_init)
            trans_state_next = TRANS_ARMED;
        end
        TRANS_ARMED:
        begin
          if (trans_init)
            trans_state_next = TRANS_ARMED;
          else if (trig_accept && !continuous_out) // RQ17
            trans_state_next = TRANS_IDLE;
          else if (trig_accept) // RQ20
            trans_state_next = TRANS_ARMED;
        end
        default:
          trans_state_next = TRANS_IDLE;
      endcase
    end
  end

  // acquire sequence, armed by initiate, closed by completion
  always @*
  begin
    acquire_armed_next = acquire_armed_out;
    if (abort_now)
      acquire_armed_next = 1'b0; // RQ12
    else if (acq_init)
      acquire_armed_next = 1'b1;
    else if (acquire_done_in)
      acquire_armed_next = 1'b0;
  end

  // abort reloads the pending level from the immediate one
  always @*
  begin
    pending_next = pending_level_out;
    output_next = output_level_out;
    if (abort_now)
      pending_next = immediate_level_in; // RQ12
    else
    begin
      if (pending_write_in)
        pending_next = pending_level_in;
      if (trig_accept) // RQ18
        output_next = pending_level_out;
    end
  end

  // transient state and its armed read-back
  always @(posedge clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      trans_state_reg <= TRANS_IDLE;
      transient_armed_out <= 1'b0;
    end
    else
    begin
      trans_state_reg <= trans_state_next;
      transient_armed_out <= (trans_state_next == TRANS_ARMED);
    end
  end

  // acquire armed read-back
  always @(posedge clk_in or posedge reset_in)
  begin
    if (reset_in)
      acquire_armed_out <= 1'b0;
    else
      acquire_armed_out <= acquire_armed_next;
  end

  // continuous mode survives abort
  always @(posedge clk_in or posedge reset_in)
  begin
    if (reset_in)
      continuous_out <= 1'b0;
    else if (continuous_write_in)
      continuous_out <= continuous_in;
  end

  // pending and applied levels
  always @(posedge clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      output_level_out <= {`LEVEL_WIDTH{1'b0}};
      pending_level_out <= {`LEVEL_WIDTH{1'b0}};
    end
    else
    begin
      output_level_out <= output_next;
      pending_level_out <= pending_next;
    end
  end

  // one-cycle pulse in the cycle after a trigger is accepted, alongside the applied level
  always @(posedge clk_in or posedge reset_in)
  begin
    if (reset_in)
      level_applied_out <= 1'b0;
    else
      level_applied_out <= trig_accept;
  end

  // either sequence still waiting keeps the flag up
  always @(posedge clk_in or posedge reset_in)
  begin
    if (reset_in)
      waiting_for_trigger_flag_out <= 1'b0;
    else
      waiting_for_trigger_flag_out <= // RQ13 RQ19 RQ20
        (trans_state_next == TRANS_ARMED) | acquire_armed_next;
  end
endmodule // status_filter_trigger_control

// file: test/host_model.sv
// remote host model issuing initiate and bus trigger commands
`timescale 1ns/1ns
module host_model
(
  // clock and requests from the bench
  input wire clk_in,
  input wire go_in,
  input wire arm_in,
  input wire [1:0] seq_in,
  input wire wtg_in,
  // commands to the device
  output logic initiate_out,
  output logic [1:0] seq_out,
  output logic trig_out,
  output logic done_out
);
  int n;
  initial
  begin
    initiate_out = 1'b0;
    seq_out = 2'h1;
    trig_out = 1'b0;
    done_out = 1'b0;
    forever
    begin
      @(posedge clk_in);
      if (go_in === 1'b1)
      begin
        #1;
        // initiate before each trigger unless told to skip it
        if (arm_in)
        begin
          initiate_out = 1'b1;
          seq_out = seq_in;
          @(posedge clk_in) #1 initiate_out = 1'b0;
          for (n = 0; n < 8 && wtg_in !== 1'b1; n++)
            @(posedge clk_in) #1;
        end
        // bus is the only transient trigger source
        trig_out = 1'b1;
        @(posedge clk_in) #1 trig_out = 1'b0;
        done_out = 1'b1;
        @(posedge clk_in) #1 done_out = 1'b0;
      end
    end
  end
endmodule // host_model

// file: test/status_filter_trigger_control_asserts.sv
// concurrent checks on the status and trigger block ports
`timescale 1ns/1ns
module trig_checker
(
  // watched ports
  input wire clk_in, reset_in, abort_in, recall_in, reset_cmd_in,
  input wire initiate_in, bus_trigger_in, continuous_out, rising_write_in,
  input wire error_read_in, error_empty_out, remote_error_in,
  input wire front_panel_error_in, display_error_valid_out,
  input wire level_applied_out, transient_armed_out, acquire_armed_out,
  input wire waiting_for_trigger_flag_out,
  input wire [14:0] write_data_in, rising_edge_filter_out,
  input wire [15:0] immediate_level_in, pending_level_out, output_level_out,
  input wire [15:0] error_num_in, error_read_num_out, display_error_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (reset_in);
  wire ab = abort_in | recall_in | reset_cmd_in;
  wire take = bus_trigger_in & transient_armed_out & ~ab;
  abort_clears_wait_a: assert property (ab |=>
    waiting_for_trigger_flag_out == $past(continuous_out)) else $error("wait flag after abort");
  abort_reload_a: assert property (ab |=>
    pending_level_out == $past(immediate_level_in)) else $error("pending not reloaded");
  trigger_apply_a: assert property (take |=> level_applied_out &&
    output_level_out == $past(pending_level_out)) else $error("level not applied");
  idle_ignore_a: assert property (!transient_armed_out |=>
    !level_applied_out) else $error("trigger taken unarmed");
  single_shot_a: assert property (take && !continuous_out && !initiate_in
    |=> !transient_armed_out) else $error("armed after single trigger");
  cont_rearm_a: assert property (take && continuous_out |=>
    transient_armed_out && waiting_for_trigger_flag_out) else $error("no rearm");
  wait_or_a: assert property (waiting_for_trigger_flag_out ==
    (transient_armed_out | acquire_armed_out)) else $error("wait flag not or");
  empty_read_a: assert property (error_read_in && error_empty_out &&
    !remote_error_in |=> error_read_num_out == 16'h0000) else $error("empty read");
  panel_show_a: assert property (front_panel_error_in |=> display_error_valid_out
    && display_error_out == $past(error_num_in)) else $error("panel error");
  filter_write_a: assert property (rising_write_in |=>
    rising_edge_filter_out == $past(write_data_in)) else $error("filter write");
  cover property (take && continuous_out);
  cover property (ab && continuous_out);
  cover property (error_read_in && error_empty_out);
endmodule // trig_checker
bind status_filter_trigger_control trig_checker chk (.*);

// file: test/testbench.sv
// self-checking bench for the status filter and trigger block
`timescale 1ns/1ns
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin n_fail++; \
  $display("ERROR %0t %h %h", $time, a, b); end end
module testbench;
  int n_fail = 0, checked = 0, i;
  logic clk_in = 0, reset_in = 1, falling_write_in = 0, rising_write_in = 0;
  logic enable_write_in = 0, event_read_in = 0, remote_error_in = 0;
  logic front_panel_error_in = 0, error_read_in = 0, continuous_write_in = 0;
  logic continuous_in = 0, acquire_done_in = 0, pending_write_in = 0;
  logic go = 0, arm = 0, done, initiate_in, bus_trigger_in;
  logic [2:0] ab = 3'h0;
  logic [1:0] sq = 2'h1, initiate_seq_in;
  logic [14:0] write_data_in = 15'h0000, condition_in = 15'h0000;
  logic [15:0] error_num_in = 16'h0000, immediate_level_in = 16'h00AA;
  logic [15:0] pending_level_in = 16'h0000;
  logic [14:0] falling_edge_filter_out, rising_edge_filter_out, questionable_summary_enable_out;
  logic [14:0] event_read_data_out, condition_out;
  logic [15:0] error_read_num_out, display_error_out, output_level_out;
  logic [15:0] pending_level_out;
  logic [3:0] error_count_out;
  logic questionable_summary_out, error_empty_out, display_error_valid_out;
  logic waiting_for_trigger_flag_out, transient_armed_out, acquire_armed_out;
  logic continuous_out, level_applied_out;
  status_filter_trigger_control dut (.abort_in(ab[0]), .recall_in(ab[1]),
    .reset_cmd_in(ab[2]), .*);
  host_model host (.clk_in(clk_in), .go_in(go), .arm_in(arm), .seq_in(sq),
    .wtg_in(waiting_for_trigger_flag_out), .initiate_out(initiate_in),
    .seq_out(initiate_seq_in), .trig_out(bus_trigger_in), .done_out(done));
  initial
  begin
    forever #20 clk_in = ~clk_in;
  end
  task tick(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  task complete_run;
    if (n_fail == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task set_pending(input logic [15:0] v);
    pending_write_in = 1; pending_level_in = v; tick(1); pending_write_in = 0;
  endtask
  task host_xfer(input logic a, input logic [1:0] s);
    arm = a; sq = s; go = 1; tick(1); go = 0;
    for (i = 0; i < 20 && done !== 1'b1; i++) @(posedge clk_in);
    #1;
    if (i == 20) n_fail++;
  endtask
  task ev_step(input logic [14:0] c, ev, input logic sum);
    condition_in = c; tick(1);
    `CHK(condition_out, c)
    `CHK(questionable_summary_out, sum)
    event_read_in = 1; tick(1); event_read_in = 0;
    `CHK(event_read_data_out, ev)
    tick(1);
  endtask
  task t_filter;
    `CHK(falling_edge_filter_out, 15'h0000)
    `CHK(rising_edge_filter_out, 15'h7FFF)
    falling_write_in = 1; write_data_in = 15'h0009; tick(1); falling_write_in = 0;
    rising_write_in = 1; write_data_in = 15'h000A; tick(1); rising_write_in = 0;
    enable_write_in = 1; write_data_in = 15'h0001; tick(1); enable_write_in = 0;
    `CHK(falling_edge_filter_out, 15'h0009)
    `CHK(questionable_summary_enable_out, 15'h0001)
    ev_step(15'h000F, 15'h000A, 1'b0);
    ev_step(15'h0000, 15'h0009, 1'b1);
    ev_step(15'h0000, 15'h0000, 1'b0);
  endtask
  task t_errors;
    for (i = 1; i <= 9; i++)
    begin
      remote_error_in = 1; error_num_in = 16'(16'h0100 + i); tick(1);
    end
    remote_error_in = 0;
    `CHK(error_count_out, 4'h8)
    error_read_in = 1;
    for (i = 1; i <= 9; i++)
    begin
      tick(1);
      `CHK(error_read_num_out, i == 8 ? 16'hFEA2 : i == 9 ? 16'h0000 : 16'(16'h0100 + i))
    end
    error_read_in = 0;
    `CHK(error_empty_out, 1'b1)
    front_panel_error_in = 1; error_num_in = 16'h0777; tick(1);
    front_panel_error_in = 0;
    `CHK(display_error_out, 16'h0777)
    `CHK(error_count_out, 4'h0)
  endtask
  task t_trigger;
    set_pending(16'h1234); host_xfer(1, 2'h1);
    `CHK(output_level_out, 16'h1234)
    `CHK(waiting_for_trigger_flag_out, 1'b0)
    set_pending(16'h5678); host_xfer(0, 2'h1);
    `CHK(output_level_out, 16'h1234)
    for (int k = 0; k < 3; k++)
    begin
      set_pending(16'h5678); ab[k] = 1; tick(1); ab = 3'h0;
      `CHK(pending_level_out, 16'h00AA)
      `CHK(waiting_for_trigger_flag_out, 1'b0)
    end
    continuous_write_in = 1; continuous_in = 1; tick(1); continuous_write_in = 0;
    ab[0] = 1; tick(1); ab = 3'h0;
    `CHK(waiting_for_trigger_flag_out, 1'b1)
    set_pending(16'h4321); host_xfer(0, 2'h1);
    `CHK(output_level_out, 16'h4321)
    `CHK(transient_armed_out, 1'b1)
    continuous_write_in = 1; continuous_in = 0; tick(1); continuous_write_in = 0;
    ab[0] = 1; tick(1); ab = 3'h0;
    set_pending(16'h0F0F); host_xfer(1, 2'h2);
    `CHK(output_level_out, 16'h4321)
    `CHK(waiting_for_trigger_flag_out, 1'b1)
    acquire_done_in = 1; tick(1); acquire_done_in = 0;
    `CHK(waiting_for_trigger_flag_out, 1'b0)
  endtask
  initial
  begin
    tick(2); reset_in = 0; tick(2);
    `CHK(pending_level_out, 16'h00AA)
    t_filter;
    t_errors;
    t_trigger;
    complete_run;
  end
  initial
  begin
    #100000;
    n_fail++;
    complete_run;
  end
endmodule // testbench
